// File: hw/mbx_exec.sv
// Purpose: execution of shift, bit, flag, move, load/store, stack and control ops
// Assumes: one decoded command per accept; memories answer within the read strobe cycle
// Notes: working registers reachable over a plain read/write port
`include "mbx_exec_consts.svh"
`timescale 1ns/100ps
module mbx_exec (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // decoded command
    input wire logic i_cmd_valid,
    input wire mbx_exec_pkg::mbx_op_type i_cmd_op,
    input wire logic [4:0] i_cmd_rd,
    input wire logic [4:0] i_cmd_rr,
    input wire logic [2:0] i_cmd_bit,
    input wire logic [1:0] i_cmd_ptr_sel,
    input wire logic [1:0] i_cmd_ptr_mode,
    input wire logic [5:0] i_cmd_disp,
    input wire logic [15:0] i_cmd_addr,
    input wire logic i_debug_en,
    output logic o_ready,
    // register file port
    input wire logic [4:0] i_rf_addr,
    input wire logic [7:0] i_rf_wdata,
    input wire logic i_rf_wr,
    input wire logic i_rf_rd,
    output logic [7:0] o_rf_rdata,
    output logic [7:0] o_status,
    // data memory and stack
    output logic [15:0] o_dmem_addr,
    output logic [7:0] o_dmem_wdata,
    output logic o_dmem_we,
    output logic o_dmem_re,
    input wire logic [7:0] i_dmem_rdata,
    // program memory
    output logic [15:0] o_pmem_addr,
    output logic o_pmem_re,
    input wire logic [7:0] i_pmem_rdata,
    // control pulses
    output logic o_sleep_req,
    output logic o_wdt_restart,
    output logic o_break_req
);
    localparam int CYC_DATA = `MBX_CYC_DATA;
    localparam int CYC_PROG = `MBX_CYC_PROG;
    logic [7:0] rf_q [0:31];
    logic [7:0] status_q;
    logic [15:0] sp_q;
    mbx_exec_pkg::mbx_state_type state_q, state_d;
    logic [4:0] pend_rd_q;
    logic [7:0] prog_byte_q;
    logic accept;
    logic [7:0] rd_val, rr_val, shift_res;
    logic [4:0] ptr_lo;
    logic [15:0] ptr_val, ptr_eff, ptr_new;
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // low register index of the selected pointer pair
    function automatic logic [4:0] ptr_index(input logic [1:0] sel);
        case (sel)
            `MBX_PSEL_FIRST: ptr_index = `MBX_PTR_FIRST_LO;
            `MBX_PSEL_SECOND: ptr_index = `MBX_PTR_SECOND_LO;
            default: ptr_index = `MBX_PTR_THIRD_LO;
        endcase
    endfunction : ptr_index
    // flags after a right shift: carry is the bit shifted out
    function automatic logic [7:0] shift_flags(input logic [7:0] st, input logic [7:0] res,
                                                input logic cout);
        logic [7:0] f;
        f = st;
        f[`MBX_FLAG_C] = cout;
        f[`MBX_FLAG_Z] = (res == 8'h00);
        f[`MBX_FLAG_N] = res[7];
        f[`MBX_FLAG_V] = res[7] ^ cout;
        f[`MBX_FLAG_S] = cout; // n xor v collapses to carry
        shift_flags = f;
    endfunction : shift_flags
    ////////////////////////////////////////////////////////////////////////////
    // operand and address formation
    assign accept = i_cmd_valid && (state_q == mbx_exec_pkg::MBX_ST_IDLE);
    assign rd_val = rf_q[i_cmd_rd];
    assign rr_val = rf_q[i_cmd_rr];
    assign ptr_lo = (i_cmd_op == mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ) ?
                    `MBX_PTR_THIRD_LO : ptr_index(i_cmd_ptr_sel);
    assign ptr_val = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
    // effective address and written-back pointer
    always_comb begin
        ptr_eff = ptr_val;
        ptr_new = ptr_val;
        if (i_cmd_op == mbx_exec_pkg::MBX_OP_OFFSET_LOAD ||
            i_cmd_op == mbx_exec_pkg::MBX_OP_OFFSET_STORE) begin
            ptr_eff = ptr_val + {10'h000, i_cmd_disp};
        end else if (i_cmd_ptr_mode == `MBX_PMODE_PRE_DEC) begin
            ptr_eff = ptr_val - 16'h0001;
            ptr_new = ptr_eff;
        end else if (i_cmd_ptr_mode == `MBX_PMODE_POST_INC) begin
            ptr_new = ptr_val + 16'h0001;
        end
    end
    // right shift result; rotate feeds carry in, shift repeats the sign
    assign shift_res = (i_cmd_op == mbx_exec_pkg::MBX_OP_ROTATE_RIGHT_CARRY) ?
        {status_q[`MBX_FLAG_C], rd_val[7:1]} : {rd_val[7], rd_val[7:1]};
    ////////////////////////////////////////////////////////////////////////////
    // sequencing: memory ops stay busy so their cycle counts are honoured
    always_comb begin
        state_d = state_q;
        case (state_q)
            mbx_exec_pkg::MBX_ST_IDLE: begin
                if (accept) begin
                    case (i_cmd_op)
                        mbx_exec_pkg::MBX_OP_INDIRECT_LOAD,
                        mbx_exec_pkg::MBX_OP_OFFSET_LOAD,
                        mbx_exec_pkg::MBX_OP_DIRECT_LOAD,
                        mbx_exec_pkg::MBX_OP_POP: state_d = mbx_exec_pkg::MBX_ST_LOAD_WAIT;
                        mbx_exec_pkg::MBX_OP_INDIRECT_STORE,
                        mbx_exec_pkg::MBX_OP_OFFSET_STORE,
                        mbx_exec_pkg::MBX_OP_DIRECT_STORE,
                        mbx_exec_pkg::MBX_OP_PUSH: state_d = mbx_exec_pkg::MBX_ST_STORE_WAIT;
                        mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ:
                            state_d = mbx_exec_pkg::MBX_ST_PROG_FETCH;
                        default: state_d = mbx_exec_pkg::MBX_ST_IDLE;
                    endcase
                end
            end
            mbx_exec_pkg::MBX_ST_PROG_FETCH: state_d = mbx_exec_pkg::MBX_ST_PROG_WRITE;
            default: state_d = mbx_exec_pkg::MBX_ST_IDLE;
        endcase
    end
    // state, pending destination and ready
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= mbx_exec_pkg::MBX_ST_IDLE;
            pend_rd_q <= 5'h00;
            prog_byte_q <= 8'h00;
            o_ready <= 1'b1;
        end else begin
            state_q <= state_d;
            o_ready <= (state_d == mbx_exec_pkg::MBX_ST_IDLE);
            if (accept) begin
                pend_rd_q <= i_cmd_rd;
            end
            if (state_q == mbx_exec_pkg::MBX_ST_PROG_FETCH) begin
                prog_byte_q <= i_pmem_rdata;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // working registers; core writes follow the port write so they win
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else begin
            if (i_rf_wr) begin
                rf_q[i_rf_addr] <= i_rf_wdata;
            end
            if (accept) begin
                case (i_cmd_op)
                    mbx_exec_pkg::MBX_OP_ROTATE_RIGHT_CARRY,
                    mbx_exec_pkg::MBX_OP_ARITH_SHIFT_RIGHT: rf_q[i_cmd_rd] <= shift_res;
                    mbx_exec_pkg::MBX_OP_NIBBLE_SWAP:
                        rf_q[i_cmd_rd] <= {rd_val[3:0], rd_val[7:4]};
                    mbx_exec_pkg::MBX_OP_TRANSFER_FLAG_TO_BIT:
                        rf_q[i_cmd_rd][i_cmd_bit] <= status_q[`MBX_FLAG_T];
                    mbx_exec_pkg::MBX_OP_MOVE: rf_q[i_cmd_rd] <= rr_val;
                    mbx_exec_pkg::MBX_OP_REGISTER_PAIR_COPY: begin
                        rf_q[{i_cmd_rd[4:1], 1'b0}] <= rf_q[{i_cmd_rr[4:1], 1'b0}];
                        rf_q[{i_cmd_rd[4:1], 1'b1}] <= rf_q[{i_cmd_rr[4:1], 1'b1}];
                    end
                    mbx_exec_pkg::MBX_OP_INDIRECT_LOAD,
                    mbx_exec_pkg::MBX_OP_INDIRECT_STORE,
                    mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ: begin
                        rf_q[ptr_lo] <= ptr_new[7:0];
                        rf_q[ptr_lo + 5'h01] <= ptr_new[15:8];
                    end
                    default: ;
                endcase
            end
            if (state_q == mbx_exec_pkg::MBX_ST_LOAD_WAIT) begin
                rf_q[pend_rd_q] <= i_dmem_rdata;
            end
            if (state_q == mbx_exec_pkg::MBX_ST_PROG_WRITE) begin
                rf_q[pend_rd_q] <= prog_byte_q;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // status register; memory, stack and control ops leave it alone
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            status_q <= `MBX_STATUS_RESET;
        end else if (accept) begin
            case (i_cmd_op)
                mbx_exec_pkg::MBX_OP_ROTATE_RIGHT_CARRY,
                mbx_exec_pkg::MBX_OP_ARITH_SHIFT_RIGHT:
                    status_q <= shift_flags(status_q, shift_res, rd_val[0]);
                // named variants, half carry and interrupt flag all arrive here
                mbx_exec_pkg::MBX_OP_FLAG_SET_GENERIC:
                    status_q[i_cmd_bit] <= 1'b1;
                mbx_exec_pkg::MBX_OP_FLAG_CLEAR_GENERIC:
                    status_q[i_cmd_bit] <= 1'b0;
                mbx_exec_pkg::MBX_OP_BIT_TO_TRANSFER_FLAG:
                    status_q[`MBX_FLAG_T] <= rr_val[i_cmd_bit];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // memory requests, issued on the accept edge
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dmem_addr <= 16'h0000;
            o_dmem_wdata <= 8'h00;
            o_dmem_we <= 1'b0;
            o_dmem_re <= 1'b0;
            o_pmem_addr <= 16'h0000;
            o_pmem_re <= 1'b0;
        end else begin
            o_dmem_we <= 1'b0;
            o_dmem_re <= 1'b0;
            o_pmem_re <= 1'b0;
            if (accept) begin
                o_dmem_wdata <= rr_val;
                case (i_cmd_op)
                    mbx_exec_pkg::MBX_OP_INDIRECT_LOAD,
                    mbx_exec_pkg::MBX_OP_OFFSET_LOAD: begin
                        o_dmem_addr <= ptr_eff;
                        o_dmem_re <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_DIRECT_LOAD: begin
                        o_dmem_addr <= i_cmd_addr;
                        o_dmem_re <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_INDIRECT_STORE,
                    mbx_exec_pkg::MBX_OP_OFFSET_STORE: begin
                        o_dmem_addr <= ptr_eff;
                        o_dmem_we <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_DIRECT_STORE: begin
                        o_dmem_addr <= i_cmd_addr;
                        o_dmem_we <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_PUSH: begin
                        o_dmem_addr <= sp_q;
                        o_dmem_we <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_POP: begin
                        o_dmem_addr <= sp_q + 16'h0001;
                        o_dmem_re <= 1'b1;
                    end
                    mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ: begin
                        o_pmem_addr <= ptr_val;
                        o_pmem_re <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end
    // stack pointer: push writes then moves down, pop moves up then reads
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sp_q <= `MBX_SP_RESET;
        end else if (accept && i_cmd_op == mbx_exec_pkg::MBX_OP_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end else if (accept && i_cmd_op == mbx_exec_pkg::MBX_OP_POP) begin
            sp_q <= sp_q + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // control pulses, one cycle each; break is a no-op without the debugger
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sleep_req <= 1'b0;
            o_wdt_restart <= 1'b0;
            o_break_req <= 1'b0;
        end else begin
            o_sleep_req <= accept && i_cmd_op == mbx_exec_pkg::MBX_OP_SLEEP;
            o_wdt_restart <= accept && i_cmd_op == mbx_exec_pkg::MBX_OP_WATCHDOG_RESTART;
            o_break_req <= accept && i_cmd_op == mbx_exec_pkg::MBX_OP_BREAK && i_debug_en;
        end
    end
    // register read port and status view
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rf_rdata <= 8'h00;
            o_status <= `MBX_STATUS_RESET;
        end else begin
            o_rf_rdata <= i_rf_rd ? rf_q[i_rf_addr] : 8'h00;
            o_status <= status_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_load_issue;
        o_dmem_re && !o_ready ##1 o_ready;
    endsequence
    sequence seq_prog_issue;
        o_pmem_re ##1 !o_ready ##1 o_ready;
    endsequence

    AST_ROTATE_RESULT: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_ROTATE_RIGHT_CARRY |=>
        rf_q[$past(i_cmd_rd)] == {$past(status_q[`MBX_FLAG_C]), $past(rd_val[7:1])} &&
        status_q[`MBX_FLAG_C] == $past(rd_val[0]))
        else $error("rotate result or carry wrong");
    AST_SHIFT_SIGN: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_ARITH_SHIFT_RIGHT |=>
        rf_q[$past(i_cmd_rd)][7:6] == {2{$past(rd_val[7])}})
        else $error("arithmetic shift lost sign");
    AST_BIT_STORE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_BIT_TO_TRANSFER_FLAG |=>
        status_q[`MBX_FLAG_T] == $past(rr_val[i_cmd_bit]) &&
        status_q[5:0] == $past(status_q[5:0]))
        else $error("bit store wrong");
    AST_FLAG_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_FLAG_SET_GENERIC |=>
        status_q[$past(i_cmd_bit)] ##1 o_status[$past(i_cmd_bit, 2)])
        else $error("flag set not seen");
    AST_LOAD_TWO: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_DIRECT_LOAD |=>
        o_dmem_addr == $past(i_cmd_addr) ##0 seq_load_issue)
        else $error("direct load not two cycles");
    AST_PREDEC_ADDR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_INDIRECT_LOAD &&
        i_cmd_ptr_mode == `MBX_PMODE_PRE_DEC |=> o_dmem_addr == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement address wrong");
    AST_OFFSET_KEEPS_PTR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_OFFSET_STORE && !i_rf_wr |=>
        o_dmem_we && {rf_q[$past(ptr_lo) + 5'h01], rf_q[$past(ptr_lo)]} == $past(ptr_val))
        else $error("offset store moved pointer");
    AST_PROG_THREE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ |=>
        seq_prog_issue ##0 rf_q[$past(i_cmd_rd, CYC_PROG)] == $past(i_pmem_rdata, CYC_DATA))
        else $error("program read not three cycles");
    AST_PUSH_FLAGS: assert property (@(posedge i_core_clk) disable iff (i_rst)
        accept && i_cmd_op == mbx_exec_pkg::MBX_OP_PUSH |=>
        o_dmem_we && $stable(status_q) && sp_q == $past(sp_q) - 16'h0001)
        else $error("push wrong");
    AST_BREAK_GATED: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_break_req |-> $past(i_debug_en))
        else $error("break without debug");
endmodule : mbx_exec

// File: pkg/mbx_exec_consts.svh
// Purpose: constants for the bit-operation and transfer execution unit
// Assumes: 8-bit data path, 16-bit data and program addresses
// Notes: flag positions and pointer pair indices of the working registers
`ifndef MBX_EXEC_CONSTS_SVH
`define MBX_EXEC_CONSTS_SVH
// status register field positions
`define MBX_FLAG_C 3'h0
`define MBX_FLAG_Z 3'h1
`define MBX_FLAG_N 3'h2
`define MBX_FLAG_V 3'h3
`define MBX_FLAG_S 3'h4
`define MBX_FLAG_H 3'h5
`define MBX_FLAG_T 3'h6
`define MBX_FLAG_I 3'h7
`define MBX_STATUS_RESET 8'h00
// low register of each pointer pair
`define MBX_PTR_FIRST_LO 5'h1A
`define MBX_PTR_SECOND_LO 5'h1C
`define MBX_PTR_THIRD_LO 5'h1E
// pointer select and update modes
`define MBX_PSEL_FIRST 2'h0
`define MBX_PSEL_SECOND 2'h1
`define MBX_PSEL_THIRD 2'h2
`define MBX_PMODE_PLAIN 2'h0
`define MBX_PMODE_POST_INC 2'h1
`define MBX_PMODE_PRE_DEC 2'h2
// stack pointer after reset
`define MBX_SP_RESET 16'hFFFF
// timing: core clock period and cycles per instruction class
`define MBX_CLK_PERIOD_NS 25
`define MBX_CYC_SIMPLE 1
`define MBX_CYC_DATA 2
`define MBX_CYC_PROG 3
`endif

// File: pkg/mbx_exec_pkg.sv
// Purpose: types shared by the execution unit and its bench
// Assumes: nothing beyond the constants header
// Notes: operation codes are already decoded by the fetch stage
package mbx_exec_pkg;
    typedef enum logic [4:0] {
        MBX_OP_NOP,
        MBX_OP_ROTATE_RIGHT_CARRY,
        MBX_OP_ARITH_SHIFT_RIGHT,
        MBX_OP_NIBBLE_SWAP,
        MBX_OP_FLAG_SET_GENERIC,
        MBX_OP_FLAG_CLEAR_GENERIC,
        MBX_OP_BIT_TO_TRANSFER_FLAG,
        MBX_OP_TRANSFER_FLAG_TO_BIT,
        MBX_OP_MOVE,
        MBX_OP_REGISTER_PAIR_COPY,
        MBX_OP_INDIRECT_LOAD,
        MBX_OP_OFFSET_LOAD,
        MBX_OP_DIRECT_LOAD,
        MBX_OP_INDIRECT_STORE,
        MBX_OP_OFFSET_STORE,
        MBX_OP_DIRECT_STORE,
        MBX_OP_PROGRAM_MEMORY_READ,
        MBX_OP_PUSH,
        MBX_OP_POP,
        MBX_OP_SLEEP,
        MBX_OP_WATCHDOG_RESTART,
        MBX_OP_BREAK
    } mbx_op_type;

    typedef enum logic [2:0] {
        MBX_ST_IDLE,
        MBX_ST_LOAD_WAIT,
        MBX_ST_STORE_WAIT,
        MBX_ST_PROG_FETCH,
        MBX_ST_PROG_WRITE
    } mbx_state_type;
endpackage : mbx_exec_pkg

// File: test/mbx_mem_model.sv
// Purpose: data, stack and program memory beside the execution unit
// Assumes: read data is wanted within the read strobe cycle
// Notes: idle read lines show the inverse of their last value
`timescale 1ns/100ps
module mbx_mem_model (
    // clock
    input wire logic i_clk,
    // data memory and stack
    input wire logic [15:0] i_daddr,
    input wire logic [7:0] i_dwdata,
    input wire logic i_dwe,
    input wire logic i_dre,
    output logic [7:0] o_drdata,
    // program memory
    input wire logic [15:0] i_paddr,
    input wire logic i_pre,
    output logic [7:0] o_prdata
);
    logic [7:0] mem [256];
    logic [7:0] dlast_q = 8'h00;
    logic [7:0] plast_q = 8'h00;
    // answer at once; inverted when idle so stale data never passes
    assign o_drdata = i_dre ? mem[i_daddr[7:0]] : ~dlast_q;
    assign o_prdata = i_pre ? (i_paddr[7:0] ^ 8'h5A) : ~plast_q;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
    // write port and idle pattern
    always @(posedge i_clk) begin
        dlast_q <= o_drdata;
        plast_q <= o_prdata;
        if (i_dwe) mem[i_daddr[7:0]] <= i_dwdata;
    end
endmodule : mbx_mem_model

// File: test/testbench.sv
// Purpose: self-checking bench for the execution unit
// Assumes: memory model answers within the strobe cycle
// Notes: drivers queue expected bytes and writes, a watcher compares
`timescale 1ns/100ps
module testbench;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cmd_valid = 1'b0;
    mbx_exec_pkg::mbx_op_type i_cmd_op = mbx_exec_pkg::MBX_OP_NOP;
    logic [4:0] i_cmd_rd = 5'h00, i_cmd_rr = 5'h00, i_rf_addr = 5'h00;
    logic [2:0] i_cmd_bit = 3'h0, pulses;
    logic [1:0] i_cmd_ptr_sel = 2'h0, i_cmd_ptr_mode = 2'h0;
    logic [5:0] i_cmd_disp = 6'h00;
    logic [15:0] i_cmd_addr = 16'h0000, o_dmem_addr, o_pmem_addr, p;
    logic i_debug_en = 1'b0, i_rf_wr = 1'b0, i_rf_rd = 1'b0, rd_seen = 1'b0;
    logic o_ready, o_dmem_we, o_dmem_re, o_pmem_re, o_sleep_req, o_wdt_restart, o_break_req;
    logic [7:0] i_rf_wdata = 8'h00, o_rf_rdata, o_status, o_dmem_wdata;
    logic [7:0] i_dmem_rdata, i_pmem_rdata, st = 8'h00, v, w, shadow [256], exp_q [$];
    logic [23:0] wr_q [$];
    int n_fail = 0, samples_checked = 0, seed = 3, cyc;
    mbx_exec i_dut (.i_core_clk, .i_rst, .i_cmd_valid, .i_cmd_op, .i_cmd_rd, .i_cmd_rr,
        .i_cmd_bit, .i_cmd_ptr_sel, .i_cmd_ptr_mode, .i_cmd_disp, .i_cmd_addr, .i_debug_en,
        .o_ready, .i_rf_addr, .i_rf_wdata, .i_rf_wr, .i_rf_rd, .o_rf_rdata, .o_status,
        .o_dmem_addr, .o_dmem_wdata, .o_dmem_we, .o_dmem_re, .i_dmem_rdata, .o_pmem_addr,
        .o_pmem_re, .i_pmem_rdata, .o_sleep_req, .o_wdt_restart, .o_break_req);
    mbx_mem_model i_mem (.i_clk(i_core_clk), .i_daddr(o_dmem_addr), .i_dwdata(o_dmem_wdata),
        .i_dwe(o_dmem_we), .i_dre(o_dmem_re), .o_drdata(i_dmem_rdata),
        .i_paddr(o_pmem_addr), .i_pre(o_pmem_re), .o_prdata(i_pmem_rdata));
    // 25 ns core clock
    initial forever #12.5 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        n_fail += exp_q.size() + wr_q.size(); // reads or writes that never showed up
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // register port cycle; a read queues its expected byte first
    task automatic rf(input logic wr, input logic [4:0] a, input logic [7:0] d);
        if (!wr) exp_q.push_back(d);
        @(posedge i_core_clk);
        i_rf_addr <= a;
        i_rf_wdata <= d;
        i_rf_wr <= wr;
        i_rf_rd <= !wr;
        @(posedge i_core_clk);
        i_rf_wr <= 1'b0;
        i_rf_rd <= 1'b0;
    endtask : rf
    // one command; cyc counts the cycles with ready low
    task automatic cmd(input mbx_exec_pkg::mbx_op_type op, input logic [4:0] rd, rr,
            input logic [2:0] b, input logic [1:0] sel, md, input logic [15:0] a);
        @(posedge i_core_clk);
        i_cmd_op <= op;
        i_cmd_rd <= rd;
        i_cmd_rr <= rr;
        i_cmd_bit <= b;
        i_cmd_ptr_sel <= sel;
        i_cmd_ptr_mode <= md;
        i_cmd_disp <= a[5:0];
        i_cmd_addr <= a;
        i_cmd_valid <= 1'b1;
        @(posedge i_core_clk);
        i_cmd_valid <= 1'b0;
        #1 pulses = {o_sleep_req, o_wdt_restart, o_break_req};
        for (cyc = 0; o_ready !== 1'b1 && cyc < 9; cyc++) @(posedge i_core_clk) #1;
    endtask : cmd
    // status output lags one cycle, so let two edges pass
    task automatic stchk();
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_status, st);
    endtask : stchk
    task automatic shift(input mbx_exec_pkg::mbx_op_type op, input logic [7:0] r);
        cmd(op, 5'h01, 5'h00, 3'h0, 2'h0, 2'h0, 16'h0000);
        st[4:0] = {v[0], r[7] ^ v[0], r[7], r == 8'h00, v[0]};
        rf(1'b0, 5'h01, r);
        stchk();
        v = r;
    endtask : shift
    ////////////////////////////////////////////////////////////////////////////
    // watcher: register reads the cycle after the strobe, memory writes as they pulse
    always @(posedge i_core_clk) rd_seen <= i_rf_rd;
    always @(negedge i_core_clk) begin
        if (rd_seen) chk({16'h0000, o_rf_rdata}, {16'h0000, exp_q.pop_front()});
        if (o_dmem_we) chk({o_dmem_addr, o_dmem_wdata}, wr_q.pop_front());
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge i_core_clk);
        n_fail++;
        summarize();
    end
    initial begin
        foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'hC3;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1 chk({o_ready, o_status}, 24'h100);
        for (int k = 0; k < 16; k++) begin
            cmd(k < 8 ? mbx_exec_pkg::MBX_OP_FLAG_SET_GENERIC
                : mbx_exec_pkg::MBX_OP_FLAG_CLEAR_GENERIC, 0, 0, 3'(k), 0, 0, 0);
            st[k % 8] = k < 8;
            stchk();
        end
        $display("flag test done");
        v = $random(seed);
        rf(1'b1, 5'h01, v);
        cmd(mbx_exec_pkg::MBX_OP_FLAG_SET_GENERIC, 0, 0, 3'h0, 0, 0, 0);
        st[0] = 1'b1;
        shift(mbx_exec_pkg::MBX_OP_ROTATE_RIGHT_CARRY, {1'b1, v[7:1]});
        shift(mbx_exec_pkg::MBX_OP_ARITH_SHIFT_RIGHT, {v[7], v[7:1]});
        cyc = $random(seed);
        st[6] = v[cyc[2:0]]; // before cmd, which reuses cyc as its wait counter
        cmd(mbx_exec_pkg::MBX_OP_BIT_TO_TRANSFER_FLAG, 0, 5'h01, 3'(cyc), 0, 0, 0);
        stchk();
        cmd(mbx_exec_pkg::MBX_OP_TRANSFER_FLAG_TO_BIT, 5'h04, 0, 3'h2, 0, 0, 0);
        rf(1'b0, 5'h04, {5'h00, st[6], 2'h0});
        cmd(mbx_exec_pkg::MBX_OP_NIBBLE_SWAP, 5'h01, 0, 0, 0, 0, 0);
        cmd(mbx_exec_pkg::MBX_OP_REGISTER_PAIR_COPY, 5'h0A, 5'h00, 0, 0, 0, 0);
        rf(1'b0, 5'h0B, {v[3:0], v[7:4]});
        stchk();
        $display("bit test done");
        for (int s = 0; s < 3; s++) begin
            p = 16'h0040 + 16'(s * 16);
            rf(1'b1, 5'(26 + 2 * s), p[7:0]);
            rf(1'b1, 5'(27 + 2 * s), p[15:8]);
            for (int m = 0; m < 3; m++) begin
                w = $random(seed);
                rf(1'b1, 5'h01, w);
                p = p - 16'(m == 2);
                shadow[p[7:0]] = w;
                wr_q.push_back({p, w});
                cmd(mbx_exec_pkg::MBX_OP_INDIRECT_STORE, 0, 5'h01, 0, 2'(s), 2'(m), 0);
                p = p + 16'(m == 1) - 16'(m == 2);
                cmd(mbx_exec_pkg::MBX_OP_INDIRECT_LOAD, 5'h07, 0, 0, 2'(s), 2'(m), 0);
                chk(cyc, 24'h1);
                rf(1'b0, 5'h07, shadow[p[7:0]]);
                p = p + 16'(m == 1);
                rf(1'b0, 5'(26 + 2 * s), p[7:0]);
            end
            if (s > 0) begin
                wr_q.push_back({p + 16'h003F, w});
                cmd(mbx_exec_pkg::MBX_OP_OFFSET_STORE, 0, 5'h01, 0, 2'(s), 0, 16'h003F);
                cmd(mbx_exec_pkg::MBX_OP_OFFSET_LOAD, 5'h08, 0, 0, 2'(s), 0, 16'h003F);
                rf(1'b0, 5'h08, w);
                rf(1'b0, 5'(26 + 2 * s), p[7:0]);
            end
        end
        wr_q.push_back({16'h00A5, w});
        cmd(mbx_exec_pkg::MBX_OP_DIRECT_STORE, 0, 5'h01, 0, 0, 0, 16'h00A5);
        cmd(mbx_exec_pkg::MBX_OP_DIRECT_LOAD, 5'h09, 0, 0, 0, 0, 16'h00A5);
        rf(1'b0, 5'h09, w);
        wr_q.push_back({16'hFFFF, w});
        cmd(mbx_exec_pkg::MBX_OP_PUSH, 0, 5'h01, 0, 0, 0, 0);
        chk(cyc, 24'h1);
        cmd(mbx_exec_pkg::MBX_OP_POP, 5'h0C, 0, 0, 0, 0, 0);
        rf(1'b0, 5'h0C, w);
        stchk();
        rf(1'b1, 5'h1E, 8'h37);
        rf(1'b1, 5'h1F, 8'h00);
        cmd(mbx_exec_pkg::MBX_OP_PROGRAM_MEMORY_READ, 0, 0, 0, 0, 2'h1, 0);
        chk(cyc, 24'h2);
        rf(1'b0, 5'h00, 8'h6D);
        rf(1'b0, 5'h1E, 8'h38);
        $display("memory test done");
        cmd(mbx_exec_pkg::MBX_OP_SLEEP, 0, 0, 0, 0, 0, 0);
        chk(pulses, 24'h4);
        cmd(mbx_exec_pkg::MBX_OP_WATCHDOG_RESTART, 0, 0, 0, 0, 0, 0);
        chk(pulses, 24'h2);
        cmd(mbx_exec_pkg::MBX_OP_BREAK, 0, 0, 0, 0, 0, 0);
        chk(pulses, 24'h0);
        i_debug_en <= 1'b1;
        cmd(mbx_exec_pkg::MBX_OP_BREAK, 0, 0, 0, 0, 0, 0);
        chk(pulses, 24'h1);
        stchk();
        $display("control test done");
        summarize();
    end
endmodule : testbench
